// ==== inc/pin_cfg_defines.svh ====
// register offsets, field positions and reset values of the pin drive and function select bank
// assumes a 32-bit avalon-mm slave, one register per aligned word
// Function
// - two-bit level code 00..11 maps to current level 0..3, driven to group
// - first drive register bits 7:6 port b pins 6-4, bits 5:4 pins 3,1,0
// - first drive register bits 3:2 port a pins 7-4, bits 1:0 pins 3-0
// - second drive register bits 3:2 set port c pins 6-4 level
// - second drive register bits 1:0 set port c pins 3-0 level
// - output and input function selection registers choose each shared pin function
// - drive level applies only while pin is a push-pull output
// - direction bit 0 means push-pull output, 1 input; reset to 1
`ifndef PIN_CFG_DEFINES_SVH
`define PIN_CFG_DEFINES_SVH
`define OFS_DRV0 6'h00
`define OFS_DRV1 6'h04
`define OFS_PORT_A_FUNC_SEL_0 6'h08
`define OFS_PORT_A_FUNC_SEL_1 6'h0C
`define OFS_PORT_B_FUNC_SEL_0 6'h10
`define OFS_PORT_B_FUNC_SEL_1 6'h14
`define OFS_PORT_C_FUNC_SEL_0 6'h18
`define OFS_PORT_C_FUNC_SEL_1 6'h1C
`define OFS_PORT_D_FUNC_SEL_0 6'h20
`define OFS_PORT_D_FUNC_SEL_1 6'h24
`define OFS_INPUT_ROUTE_SEL_0 6'h28
`define OFS_INPUT_ROUTE_SEL_1 6'h2C
`define OFS_DIRA 6'h30
`define OFS_DIRB 6'h34
`define OFS_DIRC 6'h38
`define OFS_DIRD 6'h3C
`define MASK_FULL 8'hFF
`define MASK_B1 8'h3F
`define MASK_C1 8'h3F
`define MASK_INPUT_ROUTE_SEL_1 8'h01
`define MASK_DIRB 8'h7F
`define MASK_DIRC 8'h7F
`define RST_SEL 8'h00
`define RST_DIR 8'hFF
`define POS_PB_HI 6
`define POS_PB_LO 4
`define POS_PA_HI 2
`define POS_PA_LO 0
`define POS_PC_HI 2
`define POS_PC_LO 0
`define POS_AUX 6
`endif

// ==== inc/pin_cfg_pkg.sv ====
// types of the pin drive and function select bank
// assumes nothing beyond a synthesizable sv tool
`default_nettype none
package pin_cfg_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACK = 3'b010,
        ST_DONE = 3'b100
    } bus_state_t;
    typedef struct packed {
        bus_state_t st;
        logic [7:0] drv0;
        logic [7:0] drv1;
        logic [7:0] port_a_func_sel_0;
        logic [7:0] port_a_func_sel_1;
        logic [7:0] port_b_func_sel_0;
        logic [7:0] port_b_func_sel_1;
        logic [7:0] port_c_func_sel_0;
        logic [7:0] port_c_func_sel_1;
        logic [7:0] port_d_func_sel_0;
        logic [7:0] port_d_func_sel_1;
        logic [7:0] input_route_sel_0;
        logic [7:0] input_route_sel_1;
        logic [7:0] dira;
        logic [7:0] dirb;
        logic [7:0] dirc;
        logic [7:0] dird;
        logic [31:0] rdata;
    } state_t;
endpackage
`default_nettype wire

// ==== design/pin_cfg.sv ====
// pin drive-strength and function selection register bank
// assumes an avalon-mm master on CLK; registers at word offsets 0x00..0x3C
`include "pin_cfg_defines.svh"
`default_nettype none
module pin_cfg #(
    parameter int ADDR_W = 6
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic [15:0] PA_LEVEL,
    output logic [13:0] PB_LEVEL,
    output logic [13:0] PC_LEVEL,
    output logic [15:0] PD_LEVEL,
    output logic [7:0] PA_OUT_EN_N,
    output logic [6:0] PB_OUT_EN_N,
    output logic [6:0] PC_OUT_EN_N,
    output logic [7:0] PD_OUT_EN_N,
    output logic [7:0] PA_FUNC_SEL0,
    output logic [7:0] PA_FUNC_SEL1,
    output logic [7:0] PB_FUNC_SEL0,
    output logic [7:0] PB_FUNC_SEL1,
    output logic [7:0] PC_FUNC_SEL0,
    output logic [7:0] PC_FUNC_SEL1,
    output logic [7:0] PD_FUNC_SEL0,
    output logic [7:0] PD_FUNC_SEL1,
    output logic [7:0] IN_ROUTE_SEL0,
    output logic [7:0] IN_ROUTE_SEL1,
    output logic [1:0] DRV_AUX_LEVEL
);
    // offsets run up to 0x3C, so a narrower address bus could never match the registers at 0x20 and above
    if (ADDR_W < 6) begin : g_bad_addr_w
        $error("ADDR_W must reach offset 0x3C");
    end

    pin_cfg_pkg::state_t s_reg;
    pin_cfg_pkg::state_t s_next;

    // byte lane 0 carries every register; other lanes are read as zero
    function automatic logic [7:0] wr_merge(input logic [7:0] old, input logic [7:0] mask,
                                            input logic [7:0] wd, input logic be);
        logic [7:0] v;
        v = be ? wd : old;
        return v & mask;
    endfunction

    // a level only reaches the pad driver while the pin is a push-pull output, else level 0
    function automatic logic [1:0] gate_lvl(input logic [1:0] code, input logic dir);
        return dir ? 2'h0 : code;
    endfunction

    // one decode serves both the read mux and the write strobes; 5'h1F means unmapped
    function automatic logic [4:0] reg_sel(input logic [ADDR_W-1:0] adr);
        logic [4:0] n;
        n = 5'h1F;
        if (adr == `OFS_DRV0) n = 5'h00;
        else if (adr == `OFS_DRV1) n = 5'h01;
        else if (adr == `OFS_PORT_A_FUNC_SEL_0) n = 5'h02;
        else if (adr == `OFS_PORT_A_FUNC_SEL_1) n = 5'h03;
        else if (adr == `OFS_PORT_B_FUNC_SEL_0) n = 5'h04;
        else if (adr == `OFS_PORT_B_FUNC_SEL_1) n = 5'h05;
        else if (adr == `OFS_PORT_C_FUNC_SEL_0) n = 5'h06;
        else if (adr == `OFS_PORT_C_FUNC_SEL_1) n = 5'h07;
        else if (adr == `OFS_PORT_D_FUNC_SEL_0) n = 5'h08;
        else if (adr == `OFS_PORT_D_FUNC_SEL_1) n = 5'h09;
        else if (adr == `OFS_INPUT_ROUTE_SEL_0) n = 5'h0A;
        else if (adr == `OFS_INPUT_ROUTE_SEL_1) n = 5'h0B;
        else if (adr == `OFS_DIRA) n = 5'h0C;
        else if (adr == `OFS_DIRB) n = 5'h0D;
        else if (adr == `OFS_DIRC) n = 5'h0E;
        else if (adr == `OFS_DIRD) n = 5'h0F;
        return n;
    endfunction

    logic [4:0] idx;
    logic [7:0] rd8;
    logic [7:0] wd8;
    logic be0;
    assign wd8 = AVS_WRITEDATA[7:0];
    assign be0 = AVS_BYTEENABLE[0];
    always_comb begin
        s_next = s_reg;
        idx = reg_sel(AVS_ADDRESS);
        rd8 = 8'h00;
        // fixed two-cycle answer keeps decode off the readdata path
        case (s_reg.st)
            pin_cfg_pkg::ST_IDLE: begin
                if (AVS_READ || AVS_WRITE) begin
                    s_next.st = pin_cfg_pkg::ST_ACK;
                end
            end
            pin_cfg_pkg::ST_ACK: begin
                s_next.st = pin_cfg_pkg::ST_DONE;
                if (idx == 5'h00) rd8 = s_reg.drv0;
                else if (idx == 5'h01) rd8 = s_reg.drv1;
                else if (idx == 5'h02) rd8 = s_reg.port_a_func_sel_0;
                else if (idx == 5'h03) rd8 = s_reg.port_a_func_sel_1;
                else if (idx == 5'h04) rd8 = s_reg.port_b_func_sel_0;
                else if (idx == 5'h05) rd8 = s_reg.port_b_func_sel_1;
                else if (idx == 5'h06) rd8 = s_reg.port_c_func_sel_0;
                else if (idx == 5'h07) rd8 = s_reg.port_c_func_sel_1;
                else if (idx == 5'h08) rd8 = s_reg.port_d_func_sel_0;
                else if (idx == 5'h09) rd8 = s_reg.port_d_func_sel_1;
                else if (idx == 5'h0A) rd8 = s_reg.input_route_sel_0;
                else if (idx == 5'h0B) rd8 = s_reg.input_route_sel_1;
                else if (idx == 5'h0C) rd8 = s_reg.dira;
                else if (idx == 5'h0D) rd8 = s_reg.dirb;
                else if (idx == 5'h0E) rd8 = s_reg.dirc;
                else if (idx == 5'h0F) rd8 = s_reg.dird;
                s_next.rdata = {24'h000000, rd8};
                if (AVS_WRITE) begin
                    // unmapped writes are accepted and dropped
                    if (idx == 5'h00) s_next.drv0 = wr_merge(s_reg.drv0, `MASK_FULL, wd8, be0);
                    else if (idx == 5'h01) s_next.drv1 = wr_merge(s_reg.drv1, `MASK_FULL, wd8, be0);
                    else if (idx == 5'h02) s_next.port_a_func_sel_0 = wr_merge(s_reg.port_a_func_sel_0, `MASK_FULL, wd8, be0);
                    else if (idx == 5'h03) s_next.port_a_func_sel_1 = wr_merge(s_reg.port_a_func_sel_1, `MASK_FULL, wd8, be0);
                    else if (idx == 5'h04) s_next.port_b_func_sel_0 = wr_merge(s_reg.port_b_func_sel_0, `MASK_FULL, wd8, be0);
                    else if (idx == 5'h05) s_next.port_b_func_sel_1 = wr_merge(s_reg.port_b_func_sel_1, `MASK_B1, wd8, be0);
                    else if (idx == 5'h06) s_next.port_c_func_sel_0 = wr_merge(s_reg.port_c_func_sel_0, `MASK_FULL, wd8, be0);
                    else if (idx == 5'h07) s_next.port_c_func_sel_1 = wr_merge(s_reg.port_c_func_sel_1, `MASK_C1, wd8, be0);
                    else if (idx == 5'h08) s_next.port_d_func_sel_0 = wr_merge(s_reg.port_d_func_sel_0, `MASK_FULL, wd8, be0);
                    else if (idx == 5'h09) s_next.port_d_func_sel_1 = wr_merge(s_reg.port_d_func_sel_1, `MASK_FULL, wd8, be0);
                    else if (idx == 5'h0A) s_next.input_route_sel_0 = wr_merge(s_reg.input_route_sel_0, `MASK_FULL, wd8, be0);
                    else if (idx == 5'h0B) s_next.input_route_sel_1 = wr_merge(s_reg.input_route_sel_1, `MASK_INPUT_ROUTE_SEL_1, wd8, be0);
                    else if (idx == 5'h0C) s_next.dira = wr_merge(s_reg.dira, `MASK_FULL, wd8, be0);
                    else if (idx == 5'h0D) s_next.dirb = wr_merge(s_reg.dirb, `MASK_DIRB, wd8, be0);
                    else if (idx == 5'h0E) s_next.dirc = wr_merge(s_reg.dirc, `MASK_DIRC, wd8, be0);
                    else if (idx == 5'h0F) s_next.dird = wr_merge(s_reg.dird, `MASK_FULL, wd8, be0);
                end
            end
            pin_cfg_pkg::ST_DONE: begin
                s_next.st = pin_cfg_pkg::ST_IDLE;
            end
            default: begin
                s_next.st = pin_cfg_pkg::ST_IDLE;
            end
        endcase
    end

    // per-pin level codes, from the register being written this cycle so outputs stay registered
    logic [1:0] code_a [8];
    logic [1:0] code_b [7];
    logic [1:0] code_c [7];
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_a
            assign code_a[g] = (g >= 4) ? s_next.drv0[`POS_PA_HI+:2] : s_next.drv0[`POS_PA_LO+:2];
        end
        for (g = 0; g < 7; g++) begin : g_b
            // pin 2 has no drive field; it sits at level 0
            assign code_b[g] = (g >= 4) ? s_next.drv0[`POS_PB_HI+:2] :
                               (g == 2) ? 2'h0 : s_next.drv0[`POS_PB_LO+:2];
        end
        for (g = 0; g < 7; g++) begin : g_c
            assign code_c[g] = (g >= 4) ? s_next.drv1[`POS_PC_HI+:2] : s_next.drv1[`POS_PC_LO+:2];
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            s_reg <= '0;
            s_reg.st <= pin_cfg_pkg::ST_IDLE;
            s_reg.drv0 <= `RST_SEL;
            s_reg.drv1 <= `RST_SEL;
            s_reg.dira <= `RST_DIR;
            s_reg.dirb <= `RST_DIR & `MASK_DIRB;
            s_reg.dirc <= `RST_DIR & `MASK_DIRC;
            s_reg.dird <= `RST_DIR;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h00000000;
            PA_LEVEL <= 16'h0000;
            PB_LEVEL <= 14'h0000;
            PC_LEVEL <= 14'h0000;
            PD_LEVEL <= 16'h0000;
            PA_OUT_EN_N <= 8'hFF;
            PB_OUT_EN_N <= 7'h7F;
            PC_OUT_EN_N <= 7'h7F;
            PD_OUT_EN_N <= 8'hFF;
            PA_FUNC_SEL0 <= 8'h00;
            PA_FUNC_SEL1 <= 8'h00;
            PB_FUNC_SEL0 <= 8'h00;
            PB_FUNC_SEL1 <= 8'h00;
            PC_FUNC_SEL0 <= 8'h00;
            PC_FUNC_SEL1 <= 8'h00;
            PD_FUNC_SEL0 <= 8'h00;
            PD_FUNC_SEL1 <= 8'h00;
            IN_ROUTE_SEL0 <= 8'h00;
            IN_ROUTE_SEL1 <= 8'h00;
            DRV_AUX_LEVEL <= 2'h0;
        end else begin
            s_reg <= s_next;
            AVS_WAITREQUEST <= (s_next.st != pin_cfg_pkg::ST_DONE);
            AVS_READDATA <= s_next.rdata;
            for (int i = 0; i < 8; i++) begin
                PA_LEVEL[2*i+:2] <= gate_lvl(code_a[i], s_next.dira[i]);
                PD_LEVEL[2*i+:2] <= 2'h0;
            end
            for (int i = 0; i < 7; i++) begin
                PB_LEVEL[2*i+:2] <= gate_lvl(code_b[i], s_next.dirb[i]);
                PC_LEVEL[2*i+:2] <= gate_lvl(code_c[i], s_next.dirc[i]);
            end
            PA_OUT_EN_N <= s_next.dira;
            PB_OUT_EN_N <= s_next.dirb[6:0];
            PC_OUT_EN_N <= s_next.dirc[6:0];
            PD_OUT_EN_N <= s_next.dird;
            // selections go straight to the pad muxes
            PA_FUNC_SEL0 <= s_next.port_a_func_sel_0;
            PA_FUNC_SEL1 <= s_next.port_a_func_sel_1;
            PB_FUNC_SEL0 <= s_next.port_b_func_sel_0;
            PB_FUNC_SEL1 <= s_next.port_b_func_sel_1;
            PC_FUNC_SEL0 <= s_next.port_c_func_sel_0;
            PC_FUNC_SEL1 <= s_next.port_c_func_sel_1;
            PD_FUNC_SEL0 <= s_next.port_d_func_sel_0;
            PD_FUNC_SEL1 <= s_next.port_d_func_sel_1;
            IN_ROUTE_SEL0 <= s_next.input_route_sel_0;
            IN_ROUTE_SEL1 <= s_next.input_route_sel_1;
            // group for this code is unknown, so it is only exported
            DRV_AUX_LEVEL <= s_next.drv1[`POS_AUX+:2];
        end
    end

    // bits 5:4 of the second drive register are plain storage; software must leave them alone

    property p_wait_two;
        @(posedge CLK) disable iff (SYS_RST)
            $rose(AVS_READ || AVS_WRITE) && s_reg.st == pin_cfg_pkg::ST_IDLE |-> AVS_WAITREQUEST ##2 !AVS_WAITREQUEST;
    endproperty
    a_wait_two: assert property (p_wait_two) else $error("waitrequest did not drop two cycles after request");
    property p_wait_one;
        @(posedge CLK) disable iff (SYS_RST) !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low for more than one cycle");
    property p_rdata_hi;
        @(posedge CLK) disable iff (SYS_RST) AVS_READDATA[31:8] == 24'h000000;
    endproperty
    a_rdata_hi: assert property (p_rdata_hi) else $error("read data upper lanes not zero");
    property p_pb1_mask;
        @(posedge CLK) disable iff (SYS_RST) s_reg.port_b_func_sel_1[7:6] == 2'h0 && s_reg.port_c_func_sel_1[7:6] == 2'h0
            && s_reg.input_route_sel_1[7:1] == 7'h00;
    endproperty
    a_pb1_mask: assert property (p_pb1_mask) else $error("unimplemented select bits set");
    property p_lvl_a;
        @(posedge CLK) disable iff (SYS_RST) !s_reg.dira[0] |-> PA_LEVEL[1:0] == s_reg.drv0[1:0];
    endproperty
    a_lvl_a: assert property (p_lvl_a) else $error("port a low level wrong");
    property p_lvl_b;
        @(posedge CLK) disable iff (SYS_RST) !s_reg.dirb[6] |-> PB_LEVEL[13:12] == s_reg.drv0[7:6];
    endproperty
    a_lvl_b: assert property (p_lvl_b) else $error("port b upper level wrong");
    property p_lvl_c;
        @(posedge CLK) disable iff (SYS_RST) !s_reg.dirc[5] |-> PC_LEVEL[11:10] == s_reg.drv1[3:2];
    endproperty
    a_lvl_c: assert property (p_lvl_c) else $error("port c upper level wrong");
    property p_lvl_c0;
        @(posedge CLK) disable iff (SYS_RST) !s_reg.dirc[0] |-> PC_LEVEL[1:0] == s_reg.drv1[1:0];
    endproperty
    a_lvl_c0: assert property (p_lvl_c0) else $error("port c lower level wrong");
    property p_input_zero;
        @(posedge CLK) disable iff (SYS_RST) s_reg.dira[7] |-> PA_LEVEL[15:14] == 2'h0;
    endproperty
    a_input_zero: assert property (p_input_zero) else $error("level on input pin");
    property p_dir_out;
        @(posedge CLK) disable iff (SYS_RST) PA_OUT_EN_N == s_reg.dira && PB_OUT_EN_N == s_reg.dirb[6:0];
    endproperty
    a_dir_out: assert property (p_dir_out) else $error("direction output mismatch");
    property p_sel;
        @(posedge CLK) disable iff (SYS_RST) PA_FUNC_SEL0 == s_reg.port_a_func_sel_0 && IN_ROUTE_SEL1 == s_reg.input_route_sel_1;
    endproperty
    a_sel: assert property (p_sel) else $error("selection output mismatch");
    property p_aux;
        @(posedge CLK) disable iff (SYS_RST) DRV_AUX_LEVEL == s_reg.drv1[7:6];
    endproperty
    a_aux: assert property (p_aux) else $error("aux level mismatch");
    // the accept edge already sees the stored value, since the write lands one edge earlier
    property p_write_lands;
        @(posedge CLK) disable iff (SYS_RST) AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `OFS_DRV0
            && AVS_BYTEENABLE[0] |-> s_reg.drv0 == AVS_WRITEDATA[7:0];
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("drive register 0 write lost");
    property p_drv1_lands;
        @(posedge CLK) disable iff (SYS_RST) AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `OFS_DRV1
            && AVS_BYTEENABLE[0] |-> s_reg.drv1 == AVS_WRITEDATA[7:0];
    endproperty
    a_drv1_lands: assert property (p_drv1_lands) else $error("drive register 1 write lost");
    property p_be_keep;
        @(posedge CLK) disable iff (SYS_RST) AVS_WRITE && !AVS_WAITREQUEST && !AVS_BYTEENABLE[0]
            |-> $stable(PA_FUNC_SEL0) && $stable(PA_LEVEL);
    endproperty
    a_be_keep: assert property (p_be_keep) else $error("write without lane 0 changed state");
    property p_lvl_a_hi;
        @(posedge CLK) disable iff (SYS_RST) !s_reg.dira[4] |-> PA_LEVEL[9:8] == s_reg.drv0[3:2];
    endproperty
    a_lvl_a_hi: assert property (p_lvl_a_hi) else $error("port a upper level wrong");
    property p_lvl_b_lo;
        @(posedge CLK) disable iff (SYS_RST) !s_reg.dirb[0] |-> PB_LEVEL[1:0] == s_reg.drv0[5:4];
    endproperty
    a_lvl_b_lo: assert property (p_lvl_b_lo) else $error("port b pin 0 level wrong");
    property p_lvl_b_mid;
        @(posedge CLK) disable iff (SYS_RST) !s_reg.dirb[3] |-> PB_LEVEL[7:6] == s_reg.drv0[5:4];
    endproperty
    a_lvl_b_mid: assert property (p_lvl_b_mid) else $error("port b pin 3 level wrong");
    property p_pb2_zero;
        @(posedge CLK) disable iff (SYS_RST) PB_LEVEL[5:4] == 2'h0;
    endproperty
    a_pb2_zero: assert property (p_pb2_zero) else $error("port b pin 2 has a level");
    property p_lvl_c6;
        @(posedge CLK) disable iff (SYS_RST) !s_reg.dirc[6] |-> PC_LEVEL[13:12] == s_reg.drv1[3:2];
    endproperty
    a_lvl_c6: assert property (p_lvl_c6) else $error("port c pin 6 level wrong");
    property p_lvl_c3;
        @(posedge CLK) disable iff (SYS_RST) !s_reg.dirc[3] |-> PC_LEVEL[7:6] == s_reg.drv1[1:0];
    endproperty
    a_lvl_c3: assert property (p_lvl_c3) else $error("port c pin 3 level wrong");
    property p_in_b;
        @(posedge CLK) disable iff (SYS_RST) s_reg.dirb[6] |-> PB_LEVEL[13:12] == 2'h0;
    endproperty
    a_in_b: assert property (p_in_b) else $error("level on port b input pin");
    property p_in_c;
        @(posedge CLK) disable iff (SYS_RST) s_reg.dirc[0] |-> PC_LEVEL[1:0] == 2'h0;
    endproperty
    a_in_c: assert property (p_in_c) else $error("level on port c input pin");
    property p_dir_cd;
        @(posedge CLK) disable iff (SYS_RST) PC_OUT_EN_N == s_reg.dirc[6:0] && PD_OUT_EN_N == s_reg.dird;
    endproperty
    a_dir_cd: assert property (p_dir_cd) else $error("port c or d direction mismatch");
    property p_sel_b;
        @(posedge CLK) disable iff (SYS_RST) PB_FUNC_SEL0 == s_reg.port_b_func_sel_0 && PB_FUNC_SEL1 == s_reg.port_b_func_sel_1;
    endproperty
    a_sel_b: assert property (p_sel_b) else $error("port b selection mismatch");
    property p_sel_c;
        @(posedge CLK) disable iff (SYS_RST) PC_FUNC_SEL0 == s_reg.port_c_func_sel_0 && PC_FUNC_SEL1 == s_reg.port_c_func_sel_1;
    endproperty
    a_sel_c: assert property (p_sel_c) else $error("port c selection mismatch");
    property p_sel_d;
        @(posedge CLK) disable iff (SYS_RST) PD_FUNC_SEL0 == s_reg.port_d_func_sel_0 && PD_FUNC_SEL1 == s_reg.port_d_func_sel_1;
    endproperty
    a_sel_d: assert property (p_sel_d) else $error("port d selection mismatch");
    property p_sel_a1;
        @(posedge CLK) disable iff (SYS_RST) PA_FUNC_SEL1 == s_reg.port_a_func_sel_1 && IN_ROUTE_SEL0 == s_reg.input_route_sel_0;
    endproperty
    a_sel_a1: assert property (p_sel_a1) else $error("port a or input route selection mismatch");
    c_write: cover property (@(posedge CLK) AVS_WRITE && !AVS_WAITREQUEST);
    c_read: cover property (@(posedge CLK) AVS_READ && !AVS_WAITREQUEST && AVS_READDATA != 32'h0);
    c_maxlvl: cover property (@(posedge CLK) PA_LEVEL[1:0] == 2'h3);
    c_pb_max: cover property (@(posedge CLK) PB_LEVEL[13:12] == 2'h3);
    c_pc_max: cover property (@(posedge CLK) PC_LEVEL[1:0] == 2'h3);
endmodule
`default_nettype wire

// ==== sim/pin_drive_and_function_select_bench.sv ====
// self-checking bench for the pin drive and function select register bank
// assumes pin_cfg with a 7-bit avalon-mm address so that 0x40 is an unmapped word
`include "pin_cfg_defines.svh"
`default_nettype none
module pin_drive_and_function_select_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [6:0] AVS_ADDRESS = 7'h00;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [3:0] AVS_BYTEENABLE = 4'h0;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST;
    logic [15:0] PA_LEVEL, PD_LEVEL;
    logic [13:0] PB_LEVEL, PC_LEVEL;
    logic [7:0] PA_OUT_EN_N, PD_OUT_EN_N;
    logic [6:0] PB_OUT_EN_N, PC_OUT_EN_N;
    logic [7:0] pa0, pa1, pb0, pb1, pc0, pc1, pd0, pd1, if0, if1;
    logic [1:0] DRV_AUX_LEVEL;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    logic rd_pend = 1'b0;
    logic [31:0] exp_q[$];
    logic [7:0] shadow[16];
    logic [7:0] masks[16] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, `MASK_B1, 8'hFF, `MASK_C1,
        8'hFF, 8'hFF, 8'hFF, `MASK_INPUT_ROUTE_SEL_1, 8'hFF, `MASK_DIRB, `MASK_DIRC, 8'hFF};

    pin_cfg #(.ADDR_W(7)) uut (.CLK(CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PA_LEVEL(PA_LEVEL),
        .PB_LEVEL(PB_LEVEL), .PC_LEVEL(PC_LEVEL), .PD_LEVEL(PD_LEVEL), .PA_OUT_EN_N(PA_OUT_EN_N),
        .PB_OUT_EN_N(PB_OUT_EN_N), .PC_OUT_EN_N(PC_OUT_EN_N), .PD_OUT_EN_N(PD_OUT_EN_N),
        .PA_FUNC_SEL0(pa0), .PA_FUNC_SEL1(pa1), .PB_FUNC_SEL0(pb0), .PB_FUNC_SEL1(pb1),
        .PC_FUNC_SEL0(pc0), .PC_FUNC_SEL1(pc1), .PD_FUNC_SEL0(pd0), .PD_FUNC_SEL1(pd1),
        .IN_ROUTE_SEL0(if0), .IN_ROUTE_SEL1(if1), .DRV_AUX_LEVEL(DRV_AUX_LEVEL));

    initial begin
        forever #12.5 CLK = ~CLK;
    end

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        $display("CHECK FAILED at %0t: %s", $time, msg);
        n_mismatch++;
    endtask

    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) fail($sformatf("read data %h, expected %h", got, exp));
    endtask

    task automatic cmp_out(input logic [127:0] got, input logic [127:0] exp, input string what);
        checked++;
        if (got !== exp) fail($sformatf("%s is %h, expected %h", what, got, exp));
    endtask

    // request stands until the rising edge that samples waitrequest low; released right after it
    task automatic xfer(input logic wr, input logic [6:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_READ <= !wr;
        AVS_WRITE <= wr;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= be;
        rd_pend <= !wr;
        do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        rd_pend <= 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        exp_q.push_back({24'h0, exp});
        xfer(1'b0, a, $urandom, 4'hF);
    endtask

    task automatic wr(input int i, input logic [7:0] d, input logic [3:0] be);
        xfer(1'b1, 7'(i * 4), {24'($urandom), d}, be);
        if (be[0]) shadow[i] = d & masks[i];
    endtask

    task automatic rd_all();
        for (int i = 0; i < 16; i++) rd(7'(i * 4), shadow[i]);
    endtask

    // level of a port a, b or c pin is its group code while it is a push-pull output, else 0; port b pin 2 and port d are always 0
    task automatic chk_outputs();
        logic [15:0] ea;
        logic [13:0] eb, ec;
        @(negedge CLK);
        for (int i = 0; i < 8; i++) ea[2*i+:2] = shadow[12][i] ? 2'b00 : (i >= 4 ? shadow[0][3:2] : shadow[0][1:0]);
        for (int i = 0; i < 7; i++) begin
            eb[2*i+:2] = (shadow[13][i] || i == 2) ? 2'b00 : (i >= 4 ? shadow[0][7:6] : shadow[0][5:4]);
            ec[2*i+:2] = shadow[14][i] ? 2'b00 : (i >= 4 ? shadow[1][3:2] : shadow[1][1:0]);
        end
        cmp_out(128'(PA_LEVEL), 128'(ea), "port a levels");
        cmp_out(128'(PB_LEVEL), 128'(eb), "port b levels");
        cmp_out(128'(PC_LEVEL), 128'(ec), "port c levels");
        cmp_out(128'(PD_LEVEL), 128'h0, "port d levels");
        cmp_out(128'(DRV_AUX_LEVEL), 128'(shadow[1][7:6]), "aux level");
        cmp_out(128'({PA_OUT_EN_N, PB_OUT_EN_N, PC_OUT_EN_N, PD_OUT_EN_N}),
            128'({shadow[12], shadow[13][6:0], shadow[14][6:0], shadow[15]}), "directions");
        cmp_out(128'({pa0, pa1, pb0, pb1, pc0, pc1, pd0, pd1, if0, if1}), 128'({shadow[2], shadow[3], shadow[4],
            shadow[5], shadow[6], shadow[7], shadow[8], shadow[9], shadow[10], shadow[11]}), "selects");
    endtask

    task automatic do_reset();
        @(posedge CLK);
        SYS_RST <= 1'b1;
        repeat (5) @(posedge CLK);
        SYS_RST <= 1'b0;
        for (int i = 0; i < 16; i++) shadow[i] = (i >= 12) ? (`RST_DIR & masks[i]) : `RST_SEL;
        chk_outputs();
        rd_all();
    endtask

    // read data is taken at the same rising edge that sees waitrequest low
    always @(posedge CLK) begin
        if (rd_pend && AVS_WAITREQUEST === 1'b0) begin
            if (exp_q.size() == 0) fail("read answer with no expectation");
            else cmp_rd(AVS_READDATA, exp_q.pop_front());
        end
    end

    always @(posedge CLK) begin
        cycles++;
        if (cycles == 8000) begin
            fail("run timed out");
            print_verdict();
        end
    end

    initial begin
        logic [7:0] d;
        logic [1:0] c;
        void'($urandom(32'hc11f6579));
        do_reset();
        $display("reset values test done");
        for (int i = 0; i < 16; i++) begin
            d = 8'($urandom);
            if (i == 1) d[5:4] = 2'b00;
            wr(i, d, 4'h1);
        end
        rd_all();
        wr(2, ~shadow[2], 4'hE);
        rd(7'h08, shadow[2]);
        xfer(1'b1, 7'h40, 32'hFF, 4'hF);
        rd(7'h40, 8'h00);
        rd_all();
        chk_outputs();
        $display("access and mask test done");
        // bring a shared function up: selection first, then the pin turned to input
        wr(2, 8'h02, 4'h1);
        wr(12, 8'h0F, 4'h1);
        chk_outputs();
        // hand the pin back only once the peripheral side is off
        wr(2, 8'h00, 4'h1);
        chk_outputs();
        $display("function select order test done");
        for (int k = 0; k < 12; k++) begin
            c = 2'(k);
            for (int i = 12; i < 16; i++) wr(i, k < 4 ? 8'h00 : 8'($urandom), 4'h1);
            wr(0, k < 4 ? {4{c}} : 8'($urandom), 4'h1);
            d = k < 4 ? {c, 2'b00, c, c} : 8'($urandom);
            d[5:4] = 2'b00;
            wr(1, d, 4'h1);
            chk_outputs();
        end
        $display("drive level test done");
        do_reset();
        $display("second reset test done");
        print_verdict();
    end
endmodule
`default_nettype wire
